// >>> kfe_ctrl.sv
// Purpose: axi4-lite register bank for four-lane fec error control and an master override
// Assumes: lane inputs synchronous to aclk; one read and one write in flight at most
// Notes:   reconfiguration words sit in the same register space, index = lane*0x400 + word
`timescale 1ns/100ps
`default_nettype none
`include "kfe_params.svh"
module kfe_ctrl #(
  parameter int         ADDR_W          = 16,
  parameter logic [3:0] AN_MASTER_LANE  = 4'h1
) (
  // clock and reset
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  // axi4-lite write address
  input  wire logic [ADDR_W-1:0]             awaddr,
  input  wire logic [2:0]                    awprot,
  input  wire logic                          awvalid,
  output logic                               awready,
  // axi4-lite write data and response
  input  wire logic [31:0]                   wdata,
  input  wire logic [3:0]                    wstrb,
  input  wire logic                          wvalid,
  output logic                               wready,
  output logic [1:0]                         bresp,
  output logic                               bvalid,
  input  wire logic                          bready,
  // axi4-lite read
  input  wire logic [ADDR_W-1:0]             araddr,
  input  wire logic [2:0]                    arprot,
  input  wire logic                          arvalid,
  output logic                               arready,
  output logic [31:0]                        rdata,
  output logic [1:0]                         rresp,
  output logic                               rvalid,
  input  wire logic                          rready,
  // lane status from the fec receive side
  input  wire kfe_pkg::kfe_lane_in_t [3:0]   lane_in,
  // lane controls toward the fec transmit side
  output logic [3:0]                         tx_fec_err_insert,
  output kfe_pkg::kfe_err_type_t [3:0]       err_type,
  // auto-negotiation master, one-hot
  output logic [3:0]                         an_master_lane,
  // interrupt
  output logic                               irq
);
  import kfe_pkg::*;

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  // which lane an error control index belongs to; bit 2 flags a hit
  function automatic logic [2:0] ctrl_lane(input logic [`KFE_IDX_W-1:0] idx);
    unique case (idx)
      `KFE_IDX_LANE0_CTRL: return 3'h4;
      `KFE_IDX_LANE1_CTRL: return 3'h5;
      `KFE_IDX_LANE2_CTRL: return 3'h6;
      `KFE_IDX_LANE3_CTRL: return 3'h7;
      default:             return 3'h0;
    endcase
  endfunction

  // reconfiguration word inside a lane window: upper bits must be clear
  function automatic logic rcfg_hit(input logic [`KFE_IDX_W-1:0] idx, input logic [9:0] lo);
    return (idx[`KFE_IDX_W-1:12] == '0) && (idx[9:0] == lo);
  endfunction

  // pick one byte of a tally, least significant byte at the lowest word
  function automatic logic [7:0] tally_byte(input logic [31:0] cnt, input logic [1:0] sel);
    return cnt[8*sel +: 8];
  endfunction

  // one-hot test for the override lane field
  function automatic logic one_hot4(input logic [3:0] v);
    return (v != 4'h0) && ((v & (v - 4'h1)) == 4'h0);
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [3:0]                insert_bit;
  logic [3:0]                clr_tally;
  logic                      ovr_en;
  logic [3:0]                ovr_lane;
  logic [3:0]                lock_q;
  logic [3:0]                lock_prev;
  logic [`KFE_IRQ_W-1:0]     irq_status;
  logic [`KFE_IRQ_W-1:0]     irq_enable;
  logic [31:0]               corr_cnt   [4];
  logic [31:0]               uncorr_cnt [4];

  logic [`KFE_IDX_W-1:0]     w_idx;
  logic [`KFE_IDX_W-1:0]     r_idx;
  logic                      wr_go;
  logic                      rd_go;
  logic [2:0]                w_lane;
  logic                      w_mapped;
  logic [`KFE_IRQ_W-1:0]     irq_clr;
  logic [`KFE_IRQ_W-1:0]     irq_evt;
  logic [31:0]               next_rdata;
  logic                      next_rmapped;

  assign w_idx  = awaddr[`KFE_IDX_W+1:2];
  assign r_idx  = araddr[`KFE_IDX_W+1:2];
  assign w_lane = ctrl_lane(w_idx);

  // ----------------------------------------------------------------
  // axi4-lite handshakes
  // ----------------------------------------------------------------
  // address and data are taken together, so neither can run ahead of the other
  assign wr_go   = awvalid && wvalid && !bvalid;
  assign awready = wr_go;
  assign wready  = wr_go;
  assign rd_go   = arvalid && !rvalid;
  assign arready = rd_go;

  // write decode: anything not listed answers decerr
  always_comb begin
    w_mapped = 1'b0;
    if (w_lane[2]) begin
      w_mapped = 1'b1;
    end else if (w_idx == `KFE_IDX_LOCK_STATUS || w_idx == `KFE_IDX_OVR_EN ||
                 w_idx == `KFE_IDX_OVR_LANE || w_idx == `KFE_IDX_IRQ_STATUS ||
                 w_idx == `KFE_IDX_IRQ_ENABLE || w_idx == `KFE_IDX_IRQ_CLEAR) begin
      w_mapped = 1'b1;
    end else if (rcfg_hit(w_idx, `KFE_RCFG_ERR_TYPE)) begin
      w_mapped = 1'b1;
    end else if ((w_idx[`KFE_IDX_W-1:12] == '0) && (w_idx[9:0] >= `KFE_RCFG_CORR_LO) &&
                 (w_idx[9:0] <= `KFE_RCFG_UNCORR_HI)) begin
      w_mapped = 1'b1; // tallies are read-only; writes are dropped
    end
  end

  // write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= `KFE_RESP_OKAY;
    end else if (wr_go) begin
      bvalid <= 1'b1;
      bresp  <= w_mapped ? `KFE_RESP_OKAY : `KFE_RESP_DECERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // lane error control words
  // ----------------------------------------------------------------
  // insert bit reads back one for its single pulse cycle, then self clears
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      insert_bit <= 4'h0;
    end else begin
      insert_bit <= 4'h0;
      if (wr_go && w_lane[2] && wstrb[1] && wdata[`KFE_INSERT_BIT]) begin
        insert_bit[w_lane[1:0]] <= 1'b1;
      end
    end
  end

  // the pulse toward the transmit fec is exactly the self-clearing bit
  assign tx_fec_err_insert = insert_bit;

  // tally clear is a plain level that holds the counters while set
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clr_tally <= 4'h0;
    end else if (wr_go && w_lane[2] && wstrb[1]) begin
      clr_tally[w_lane[1:0]] <= wdata[`KFE_CLRTALLY_BIT];
    end
  end

  // ----------------------------------------------------------------
  // reconfiguration error type words, one per lane window
  // ----------------------------------------------------------------
  // software owns the field mix; the block only stores and drives it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      err_type <= '0;
    end else if (wr_go && wstrb[0] && rcfg_hit(w_idx, `KFE_RCFG_ERR_TYPE)) begin
      err_type[w_idx[11:10]].transcode_err <= wdata[`KFE_ET_TRANSCODE_BIT];
      err_type[w_idx[11:10]].burst_err     <= wdata[`KFE_ET_BURST_BIT];
      err_type[w_idx[11:10]].burst_len     <= wdata[`KFE_ET_LEN_MSB:`KFE_ET_LEN_LSB];
    end
  end

  // ----------------------------------------------------------------
  // auto-negotiation master override
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ovr_en <= 1'b0;
    end else if (wr_go && wstrb[0] && w_idx == `KFE_IDX_OVR_EN) begin
      ovr_en <= wdata[`KFE_OVR_EN_BIT];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ovr_lane <= `KFE_OVR_LANE_RST;
    end else if (wr_go && wstrb[0] && w_idx == `KFE_IDX_OVR_LANE) begin
      ovr_lane <= wdata[3:0];
    end
  end

  // an invalid field never reaches the lanes; the build-time lane stays in charge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      an_master_lane <= AN_MASTER_LANE;
    end else if (ovr_en && one_hot4(ovr_lane)) begin
      an_master_lane <= ovr_lane;
    end else begin
      an_master_lane <= AN_MASTER_LANE;
    end
  end

  // ----------------------------------------------------------------
  // lane status and tallies
  // ----------------------------------------------------------------
  // lock is registered so the read field and the loss event agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lock_q    <= `KFE_LOCK_RST;
      lock_prev <= `KFE_LOCK_RST;
    end else begin
      for (int i = 0; i < 4; i++) begin
        lock_q[i] <= lane_in[i].block_lock;
      end
      lock_prev <= lock_q;
    end
  end

  for (genvar g = 0; g < 4; g++) begin : g_lane
    kfe_tally #(
      .CNT_W      (32)
    ) u_tally (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .hold_clear (clr_tally[g]),
      .corr_hit   (lane_in[g].corr_blk),
      .uncorr_hit (lane_in[g].uncorr_blk),
      .corr_cnt   (corr_cnt[g]),
      .uncorr_cnt (uncorr_cnt[g])
    );
  end

  // ----------------------------------------------------------------
  // interrupts: [3:0] lock lost, [7:4] uncorrected block
  // ----------------------------------------------------------------
  always_comb begin
    irq_evt = {`KFE_IRQ_W{1'b0}};
    for (int i = 0; i < 4; i++) begin
      irq_evt[i]     = lock_prev[i] && !lock_q[i];
      irq_evt[i + 4] = lane_in[i].uncorr_blk && !clr_tally[i];
    end
  end

  assign irq_clr = (wr_go && wstrb[0] && w_idx == `KFE_IDX_IRQ_CLEAR) ?
                   wdata[`KFE_IRQ_W-1:0] : {`KFE_IRQ_W{1'b0}};

  // a new event in the clear cycle wins, so nothing is lost
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status <= `KFE_IRQ_RST;
    end else begin
      irq_status <= (irq_status & ~irq_clr) | irq_evt;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_enable <= `KFE_IRQ_RST;
    end else if (wr_go && wstrb[0] && w_idx == `KFE_IDX_IRQ_ENABLE) begin
      irq_enable <= wdata[`KFE_IRQ_W-1:0];
    end
  end

  assign irq = |(irq_status & irq_enable);

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  always_comb begin
    logic [2:0] r_lane;
    logic [1:0] rl;
    r_lane       = ctrl_lane(r_idx);
    rl           = r_idx[11:10];
    next_rdata   = `KFE_ZERO32;
    next_rmapped = 1'b1;
    if (r_lane[2]) begin
      next_rdata[`KFE_INSERT_BIT]   = insert_bit[r_lane[1:0]];
      next_rdata[`KFE_CLRTALLY_BIT] = clr_tally[r_lane[1:0]];
    end else if (r_idx == `KFE_IDX_LOCK_STATUS) begin
      next_rdata[`KFE_LOCK_MSB:`KFE_LOCK_LSB] = lock_q;
    end else if (r_idx == `KFE_IDX_OVR_EN) begin
      next_rdata[`KFE_OVR_EN_BIT] = ovr_en;
    end else if (r_idx == `KFE_IDX_OVR_LANE) begin
      next_rdata[3:0] = ovr_lane;
    end else if (r_idx == `KFE_IDX_IRQ_STATUS) begin
      next_rdata[`KFE_IRQ_W-1:0] = irq_status;
    end else if (r_idx == `KFE_IDX_IRQ_ENABLE) begin
      next_rdata[`KFE_IRQ_W-1:0] = irq_enable;
    end else if (r_idx == `KFE_IDX_IRQ_CLEAR) begin
      next_rdata = `KFE_ZERO32; // write-only
    end else if (rcfg_hit(r_idx, `KFE_RCFG_ERR_TYPE)) begin
      next_rdata[`KFE_ET_TRANSCODE_BIT]           = err_type[rl].transcode_err;
      next_rdata[`KFE_ET_BURST_BIT]               = err_type[rl].burst_err;
      next_rdata[`KFE_ET_LEN_MSB:`KFE_ET_LEN_LSB] = err_type[rl].burst_len;
    end else if ((r_idx[`KFE_IDX_W-1:12] == '0) && (r_idx[9:0] >= `KFE_RCFG_CORR_LO) &&
                 (r_idx[9:0] <= `KFE_RCFG_CORR_HI)) begin
      next_rdata[7:0] = tally_byte(corr_cnt[rl], r_idx[1:0]);
    end else if ((r_idx[`KFE_IDX_W-1:12] == '0) && (r_idx[9:0] >= `KFE_RCFG_UNCORR_LO) &&
                 (r_idx[9:0] <= `KFE_RCFG_UNCORR_HI)) begin
      next_rdata[7:0] = tally_byte(uncorr_cnt[rl], r_idx[1:0]);
    end else begin
      next_rmapped = 1'b0;
    end
  end

  // read data is captured at the address handshake and held until taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= `KFE_ZERO32;
      rresp  <= `KFE_RESP_OKAY;
    end else if (rd_go) begin
      rvalid <= 1'b1;
      rdata  <= next_rdata;
      rresp  <= next_rmapped ? `KFE_RESP_OKAY : `KFE_RESP_DECERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // protection bits carry no meaning here
  logic unused_prot;
  assign unused_prot = ^{awprot, arprot, awaddr[1:0], araddr[1:0]};

endmodule
`default_nettype wire

// >>> kfe_params.svh
// Purpose: register indices, field positions and reset values of the fec/an control block
// Assumes: byte address is four times the register index
// Notes:   definitions only
`ifndef KFE_PARAMS_SVH
`define KFE_PARAMS_SVH

// ----------------------------------------------------------------
// register indices (byte address = index * 4)
// ----------------------------------------------------------------
`define KFE_IDX_W            14
`define KFE_IDX_LOCK_STATUS  14'h00b1
`define KFE_IDX_LANE0_CTRL   14'h00b2
`define KFE_IDX_LANE1_CTRL   14'h00b5
`define KFE_IDX_LANE2_CTRL   14'h00b8
`define KFE_IDX_LANE3_CTRL   14'h00bb
`define KFE_IDX_OVR_EN       14'h00c0
`define KFE_IDX_OVR_LANE     14'h00cc
`define KFE_IDX_IRQ_STATUS   14'h00f0
`define KFE_IDX_IRQ_ENABLE   14'h00f1
`define KFE_IDX_IRQ_CLEAR    14'h00f2
// reconfiguration words, low part of index, lane in index[11:10]
`define KFE_RCFG_ERR_TYPE    10'h0bd
`define KFE_RCFG_CORR_LO     10'h0dc
`define KFE_RCFG_CORR_HI     10'h0df
`define KFE_RCFG_UNCORR_LO   10'h0e0
`define KFE_RCFG_UNCORR_HI   10'h0e3

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define KFE_LOCK_LSB         20
`define KFE_LOCK_MSB         23
`define KFE_LOCK_RST         4'h0
`define KFE_INSERT_BIT       11
`define KFE_CLRTALLY_BIT     12
`define KFE_OVR_EN_BIT       6
`define KFE_OVR_LANE_RST     4'h0
`define KFE_ET_TRANSCODE_BIT 0
`define KFE_ET_BURST_BIT     1
`define KFE_ET_LEN_LSB       4
`define KFE_ET_LEN_MSB       7
`define KFE_IRQ_W            8
`define KFE_IRQ_RST          8'h00

// ----------------------------------------------------------------
// bus answers
// ----------------------------------------------------------------
`define KFE_RESP_OKAY        2'h0
`define KFE_RESP_DECERR      2'h3
`define KFE_ZERO32           32'h0000_0000

`endif

// >>> kfe_pkg.sv
// Purpose: shared types of the fec/an control block
// Assumes: four lanes
// Notes:   constants live in kfe_params.svh
`default_nettype none
package kfe_pkg;

  // ----------------------------------------------------------------
  // per-lane carriers
  // ----------------------------------------------------------------
  // status seen from one lane's fec receive logic
  typedef struct packed {
    logic block_lock;
    logic corr_blk;
    logic uncorr_blk;
  } kfe_lane_in_t;

  // injected error type of one lane
  typedef struct packed {
    logic [3:0] burst_len;
    logic       burst_err;
    logic       transcode_err;
  } kfe_err_type_t;

endpackage
`default_nettype wire

// >>> kfe_tally.sv
// Purpose: corrected and uncorrected errored-block tallies of one lane
// Assumes: block indications are one-cycle pulses on aclk
// Notes:   tallies saturate rather than wrap
`timescale 1ns/100ps
`default_nettype none
module kfe_tally #(
  parameter int CNT_W = 32
) (
  // clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // control and events
  input  wire logic             hold_clear,
  input  wire logic             corr_hit,
  input  wire logic             uncorr_hit,
  // tallies
  output logic [CNT_W-1:0]      corr_cnt,
  output logic [CNT_W-1:0]      uncorr_cnt
);

  // saturating bump, so a long run never wraps back to a small count
  function automatic logic [CNT_W-1:0] bump(input logic [CNT_W-1:0] v, input logic hit);
    if (hit && (v != {CNT_W{1'b1}})) begin
      return v + {{(CNT_W-1){1'b0}}, 1'b1};
    end
    return v;
  endfunction

  // corrected tally, held at zero while cleared
  always_ff @(posedge aclk) begin
    if (!aresetn || hold_clear) begin
      corr_cnt <= '0;
    end else begin
      corr_cnt <= bump(corr_cnt, corr_hit);
    end
  end

  // uncorrected tally, held at zero while cleared
  always_ff @(posedge aclk) begin
    if (!aresetn || hold_clear) begin
      uncorr_cnt <= '0;
    end else begin
      uncorr_cnt <= bump(uncorr_cnt, uncorr_hit);
    end
  end

endmodule
`default_nettype wire

// >>> kfe_ctrl_monitor.sv
// Purpose: bus and lane-control checks for kfe_ctrl
// Assumes: bound to every kfe_ctrl instance, ADDR_W of 16
// Notes:   watches design inputs and outputs only
`timescale 1ns/100ps
`default_nettype none
`include "kfe_params.svh"
module kfe_ctrl_monitor #(
  parameter int         ADDR_W         = 16,
  parameter logic [3:0] AN_MASTER_LANE = 4'h1
) (
  // clock and reset
  input wire logic              aclk,
  input wire logic              aresetn,
  // register bus
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic              awvalid,
  input wire logic              awready,
  input wire logic [31:0]       wdata,
  input wire logic              wvalid,
  input wire logic [1:0]        bresp,
  input wire logic              bvalid,
  input wire logic              bready,
  input wire logic              arvalid,
  input wire logic              arready,
  input wire logic [31:0]       rdata,
  input wire logic              rvalid,
  input wire logic              rready,
  // lane controls
  input wire logic [3:0]        tx_fec_err_insert,
  input wire logic [3:0]        an_master_lane
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // writes are two cycles apart at least, so a longer pulse is a stuck bit
  insert_once_a: assert property (|tx_fec_err_insert |=> !tx_fec_err_insert)
    else $error("insert pulse longer than one cycle");
  insert_cause_a: assert property (tx_fec_err_insert[0] |->
    $past(awvalid && awready && wvalid && wdata[`KFE_INSERT_BIT] &&
          awaddr[`KFE_IDX_W+1:2] == `KFE_IDX_LANE0_CTRL))
    else $error("lane 0 insert without its write");
  wr_answer_a: assert property (awvalid && awready |=> bvalid)
    else $error("write not answered next cycle");
  rd_answer_a: assert property (arvalid && arready |=> rvalid)
    else $error("read not answered next cycle");
  wr_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write answer dropped early");
  rd_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read answer dropped early");
  master_onehot_a: assert property ($onehot(an_master_lane))
    else $error("master lane not one-hot");
  // the master lane only moves after a register write
  master_move_a: assert property (!$stable(an_master_lane) |-> $past(bvalid))
    else $error("master lane moved without a write");
  // coming out of reset the build-time lane must already be in charge
  master_reset_a: assert property ($rose(aresetn) |-> an_master_lane == AN_MASTER_LANE)
    else $error("master lane not at its build-time value after reset");
endmodule

bind kfe_ctrl kfe_ctrl_monitor #(.ADDR_W(ADDR_W), .AN_MASTER_LANE(AN_MASTER_LANE)) mon_u (
  .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
  .wdata(wdata), .wvalid(wvalid), .bresp(bresp), .bvalid(bvalid), .bready(bready),
  .arvalid(arvalid), .arready(arready), .rdata(rdata), .rvalid(rvalid), .rready(rready),
  .tx_fec_err_insert(tx_fec_err_insert), .an_master_lane(an_master_lane)
);
`default_nettype wire

// >>> kfe_ctrl_tb.sv
// Purpose: directed register-level bench for kfe_ctrl
// Assumes: aclk 10 MHz, design answers every request
// Notes:   expectations come from the register map only
`timescale 1ns/100ps
`default_nettype none
`include "kfe_params.svh"
module kfe_ctrl_tb;
  import kfe_pkg::*;
  logic                aclk = 1'b0;
  logic                aresetn = 1'b0;
  logic [15:0]         awaddr = '0, araddr = '0;
  logic                awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
  logic                rready = 1'b0;
  logic [31:0]         wdata = '0, rdata;
  logic [3:0]          wstrb = 4'hf;
  logic                awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0]          bresp, rresp;
  logic [3:0]          tx_fec_err_insert, an_master_lane;
  kfe_lane_in_t [3:0]  lane_in = '0;
  kfe_err_type_t [3:0] err_type;
  logic [7:0]          ins_cnt [4] = '{default: 8'h00};
  int                  errors = 0, checks = 0, cyc = 0;
  logic [13:0]         ctrl [4] = '{`KFE_IDX_LANE0_CTRL, `KFE_IDX_LANE1_CTRL,
                                    `KFE_IDX_LANE2_CTRL, `KFE_IDX_LANE3_CTRL};

  always #50 aclk = ~aclk;

  kfe_ctrl #(.ADDR_W(16), .AN_MASTER_LANE(4'h1)) dut_u (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .lane_in(lane_in), .tx_fec_err_insert(tx_fec_err_insert),
    .err_type(err_type), .an_master_lane(an_master_lane), .irq(irq)
  );

  // count insert pulses per lane; the cycle ceiling cuts a hang short
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    for (int l = 0; l < 4; l++)
      if (tx_fec_err_insert[l]) ins_cnt[l] <= ins_cnt[l] + 8'h01;
    if (cyc == 30000) begin
      errors = errors + 1;
      close_out();
    end
  end

  task automatic close_out();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks = checks + 1;
    if (got !== exp) begin
      errors = errors + 1;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic gap(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // both channels offered together, held until taken
  task automatic wr(input logic [13:0] idx, input logic [31:0] d,
                    input logic [1:0] er = `KFE_RESP_OKAY);
    @(posedge aclk);
    awaddr <= {idx, 2'b00};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(posedge aclk); while (!(awready && wready));
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, er});
  endtask

  task automatic rd(input logic [13:0] idx, input logic [31:0] e,
                    input logic [1:0] er = `KFE_RESP_OKAY);
    @(posedge aclk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk(rdata, e);
    chk({30'h0, rresp}, {30'h0, er});
  endtask

  // block indications, one cycle each
  task automatic pulse(input int l, input int nc, input int nu);
    for (int i = 0; i < nc || i < nu; i++) begin
      @(posedge aclk);
      lane_in[l].corr_blk <= (i < nc);
      lane_in[l].uncorr_blk <= (i < nu);
    end
    @(posedge aclk);
    lane_in[l].corr_blk <= 1'b0;
    lane_in[l].uncorr_blk <= 1'b0;
  endtask

  function automatic logic [13:0] ridx(input int l, input int w);
    return 14'(l * 1024 + w);
  endfunction

  function automatic logic [31:0] byte_of(input int v, input int b);
    return 32'((v >> (8 * b)) & 255);
  endfunction

  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`KFE_IDX_LOCK_STATUS, `KFE_ZERO32);
    chk({28'h0, an_master_lane}, 32'h0000_0001);
    for (int l = 0; l < 4; l++) begin
      rd(ctrl[l], `KFE_ZERO32);
      lane_in[l].block_lock <= !l[0];
    end
    gap(2);
    rd(`KFE_IDX_LOCK_STATUS, 32'h0050_0000);
    wr(`KFE_IDX_LOCK_STATUS, 32'hffff_ffff);
    rd(`KFE_IDX_LOCK_STATUS, 32'h0050_0000);
    // error type, then one insert per lane
    for (int l = 0; l < 4; l++) begin
      rd(ridx(l, `KFE_RCFG_ERR_TYPE), `KFE_ZERO32);
      wr(ridx(l, `KFE_RCFG_ERR_TYPE), 32'h0000_0001);
      gap(2);
      chk({26'h0, err_type[l]}, 32'h0000_0001);
      wr(ridx(l, `KFE_RCFG_ERR_TYPE), 32'h0000_0052);
      rd(ridx(l, `KFE_RCFG_ERR_TYPE), 32'h0000_0052);
      chk({26'h0, err_type[l]}, 32'h0000_0016);
      wr(ctrl[l], 32'h0000_0800);
      gap(2);
      chk({24'h0, ins_cnt[l]}, 32'h0000_0001);
      rd(ctrl[l], `KFE_ZERO32);
    end
    // insert bit lives in byte 1: a write without that strobe must not fire
    wstrb <= 4'h1;
    wr(ctrl[0], 32'h0000_0800);
    gap(2);
    chk({24'h0, ins_cnt[0]}, 32'h0000_0001);
    wstrb <= 4'hf;
    // corrected counts past one byte, distinct per lane, then hold and resume
    for (int l = 0; l < 4; l++) begin
      pulse(l, 258 + l, 3 + l);
      for (int b = 0; b < 4; b++) begin
        rd(ridx(l, `KFE_RCFG_CORR_LO + b), byte_of(258 + l, b));
        rd(ridx(l, `KFE_RCFG_UNCORR_LO + b), byte_of(3 + l, b));
      end
      wr(ctrl[l], 32'h0000_1000);
      pulse(l, 2, 2);
      rd(ridx(l, `KFE_RCFG_CORR_LO), `KFE_ZERO32);
      rd(ridx(l, `KFE_RCFG_UNCORR_LO), `KFE_ZERO32);
      rd(ctrl[l], 32'h0000_1000);
      wr(ctrl[l], `KFE_ZERO32);
      pulse(l, 1, 0);
      rd(ridx(l, `KFE_RCFG_CORR_LO), 32'h0000_0001);
    end
    // master lane: field ignored while disabled, invalid value falls back
    wr(`KFE_IDX_OVR_LANE, 32'h0000_0004);
    gap(2);
    chk({28'h0, an_master_lane}, 32'h0000_0001);
    wr(`KFE_IDX_OVR_EN, 32'h0000_0040);
    for (int k = 0; k < 5; k++) begin
      wr(`KFE_IDX_OVR_LANE, k < 4 ? 32'(1 << k) : 32'h0000_0003);
      gap(2);
      chk({28'h0, an_master_lane}, k < 4 ? 32'(1 << k) : 32'h0000_0001);
    end
    rd(`KFE_IDX_OVR_EN, 32'h0000_0040);
    wr(`KFE_IDX_OVR_LANE, 32'h0000_0008);
    wr(`KFE_IDX_OVR_EN, `KFE_ZERO32);
    gap(2);
    chk({28'h0, an_master_lane}, 32'h0000_0001);
    rd(14'h0050, `KFE_ZERO32, `KFE_RESP_DECERR);
    wr(14'h0050, 32'h0000_0001, `KFE_RESP_DECERR);
    // interrupt: lock loss, clear, uncorrected block, mask
    wr(`KFE_IDX_IRQ_CLEAR, 32'h0000_00ff);
    wr(`KFE_IDX_IRQ_ENABLE, 32'h0000_0011);
    lane_in[0].block_lock <= 1'b0;
    gap(4);
    chk({31'h0, irq}, 32'h0000_0001);
    rd(`KFE_IDX_IRQ_STATUS, 32'h0000_0001);
    wr(`KFE_IDX_IRQ_CLEAR, 32'h0000_0001);
    gap(1);
    chk({31'h0, irq}, `KFE_ZERO32);
    pulse(0, 0, 1);
    gap(1);
    chk({31'h0, irq}, 32'h0000_0001);
    wr(`KFE_IDX_IRQ_ENABLE, `KFE_ZERO32);
    gap(1);
    chk({31'h0, irq}, `KFE_ZERO32);
    rd(`KFE_IDX_IRQ_STATUS, 32'h0000_0010);
    close_out();
  end
endmodule
`default_nettype wire
